// ==== src/swreq_pkg.sv ====
// Purpose: Shared constants for the software handshake request registers
// Assumes: 32-bit AXI4-Lite register bus, three DMA channels
// Notes:   Offsets are byte addresses within the DMA register space
package swreq_pkg;

    localparam int unsigned NUM_CH   = 3;
    localparam int unsigned ADDR_W   = 12;

    // Register byte offsets
    localparam logic [11:0] SRC_SW_OFFSET     = 12'h368;
    localparam logic [11:0] DST_SW_OFFSET     = 12'h370;
    localparam logic [11:0] SRC_SINGLE_OFFSET = 12'h378;
    localparam logic [11:0] DST_SINGLE_OFFSET = 12'h380;

    // Field positions
    localparam int unsigned PEND_LSB = 0;
    localparam int unsigned GATE_LSB = 8;

    // Reset value of every request register
    localparam logic [31:0] REQ_RESET = 32'h0000_0000;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Read channel states
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_type;

endpackage

// ==== src/req_bank_if.sv ====
// Purpose: Carrier between the register decode and one request bank
// Assumes: Single clock domain
// Notes:   One instance per request register
interface req_bank_if #(parameter int unsigned N = 3);
    logic         wr_stb;
    logic [N-1:0] wr_gate;
    logic [N-1:0] wr_val;
    logic [N-1:0] done;
    logic [N-1:0] pending;

    modport ctrl (output wr_stb, output wr_gate, output wr_val, output done,
                  input pending);
    modport bank (input wr_stb, input wr_gate, input wr_val, input done,
                  output pending);
endinterface

// ==== src/req_bank.sv ====
// Purpose: One group of per-channel request bits with write gates
// Assumes: Done pulses come from logic on the same clock
// Notes:   A gated software write wins over a same-cycle service clear
module req_bank #(
    parameter int unsigned N = 3
) (
    input  wire logic    clk_in,
    input  wire logic    rst_in,
    req_bank_if.bank     port
);
    import swreq_pkg::*;

    logic [N-1:0] pending;
    logic [N-1:0] next_pending;
    logic [N-1:0] cleared;
    logic [N-1:0] mask;

    // Service clears pending bits, gated write overrides per channel
    assign cleared      = pending & ~port.done;
    assign mask         = port.wr_stb ? port.wr_gate : '0;
    assign next_pending = (cleared & ~mask) | (port.wr_val & mask);
    assign port.pending = pending;

    // Request bit storage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pending <= REQ_RESET[N-1:0];
        end else begin
            pending <= next_pending;
        end
    end

endmodule // req_bank

// ==== src/dma_sw_handshake_requests.sv ====
// Purpose: Software handshake request registers behind an AXI4-Lite slave
// Assumes: Done inputs are one-cycle pulses from the channel logic, same clock
// Notes:   One write and one read in flight at a time
// Operation
// - Source software request register, bits 2..0
// - Source software request gates in bits 10..8
// - Destination software request register, bits 2..0
// - Destination software request gates in bits 10..8
// - Source single request register, bits 2..0
// - Source single request gates in bits 10..8
// - Destination single request register, bits 2..0
// - Destination single request gates in bits 10..8
//
// Our own choice: register access over AXI4-Lite.
module dma_sw_handshake_requests (
    input  wire logic                        SYS_CLK_IN,
    input  wire logic                        RST_IN,
    input  wire logic [swreq_pkg::ADDR_W-1:0] AWADDR_IN,
    input  wire logic                        AWVALID_IN,
    output logic                             AWREADY_OUT,
    input  wire logic [31:0]                 WDATA_IN,
    input  wire logic [3:0]                  WSTRB_IN,
    input  wire logic                        WVALID_IN,
    output logic                             WREADY_OUT,
    output logic [1:0]                       BRESP_OUT,
    output logic                             BVALID_OUT,
    input  wire logic                        BREADY_IN,
    input  wire logic [swreq_pkg::ADDR_W-1:0] ARADDR_IN,
    input  wire logic                        ARVALID_IN,
    output logic                             ARREADY_OUT,
    output logic [31:0]                      RDATA_OUT,
    output logic [1:0]                       RRESP_OUT,
    output logic                             RVALID_OUT,
    input  wire logic                        RREADY_IN,
    input  wire logic [swreq_pkg::NUM_CH-1:0] SRC_SW_DONE_IN,
    input  wire logic [swreq_pkg::NUM_CH-1:0] DST_SW_DONE_IN,
    input  wire logic [swreq_pkg::NUM_CH-1:0] SRC_SINGLE_DONE_IN,
    input  wire logic [swreq_pkg::NUM_CH-1:0] DST_SINGLE_DONE_IN,
    output logic [swreq_pkg::NUM_CH-1:0]     SRC_SW_REQ_OUT,
    output logic [swreq_pkg::NUM_CH-1:0]     DST_SW_REQ_OUT,
    output logic [swreq_pkg::NUM_CH-1:0]     SRC_SINGLE_REQ_OUT,
    output logic [swreq_pkg::NUM_CH-1:0]     DST_SINGLE_REQ_OUT
);
    import swreq_pkg::*;

    localparam int unsigned N = NUM_CH;

    logic [ADDR_W-1:0] aw_addr;
    logic              aw_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_full;
    rd_state_type      rd_state;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;

    logic              aw_hs;
    logic              w_hs;
    logic              ar_hs;
    logic              do_write;
    logic              wsel_src_sw;
    logic              wsel_dst_sw;
    logic              wsel_src_single;
    logic              wsel_dst_single;
    logic              wsel_any;
    logic              lanes_ok;
    logic [N-1:0]      wr_gate;
    logic [N-1:0]      wr_val;
    logic              rsel_src_sw;
    logic              rsel_dst_sw;
    logic              rsel_src_single;
    logic              rsel_dst_single;
    logic [N-1:0]      rd_pend;

    req_bank_if #(.N(N)) src_sw_if ();
    req_bank_if #(.N(N)) dst_sw_if ();
    req_bank_if #(.N(N)) src_single_if ();
    req_bank_if #(.N(N)) dst_single_if ();

    // Handshakes on the AXI channels
    assign aw_hs    = AWVALID_IN & AWREADY_OUT;
    assign w_hs     = WVALID_IN & WREADY_OUT;
    assign ar_hs    = ARVALID_IN & ARREADY_OUT;
    assign do_write = aw_full & w_full & ~BVALID_OUT;

    // Write address decode
    assign wsel_src_sw     = (aw_addr == SRC_SW_OFFSET);
    assign wsel_dst_sw     = (aw_addr == DST_SW_OFFSET);
    assign wsel_src_single = (aw_addr == SRC_SINGLE_OFFSET);
    assign wsel_dst_single = (aw_addr == DST_SINGLE_OFFSET);
    assign wsel_any        = wsel_src_sw | wsel_dst_sw | wsel_src_single | wsel_dst_single;

    // Gate and value need both low byte lanes; other bits are dropped
    assign lanes_ok = w_strb[0] & w_strb[1];
    assign wr_gate  = lanes_ok ? w_data[GATE_LSB +: N] : '0;
    assign wr_val   = w_data[PEND_LSB +: N];

    // Bank write strobes
    assign src_sw_if.wr_stb     = do_write & wsel_src_sw;
    assign dst_sw_if.wr_stb     = do_write & wsel_dst_sw;
    assign src_single_if.wr_stb = do_write & wsel_src_single;
    assign dst_single_if.wr_stb = do_write & wsel_dst_single;
    assign src_sw_if.wr_gate     = wr_gate;
    assign dst_sw_if.wr_gate     = wr_gate;
    assign src_single_if.wr_gate = wr_gate;
    assign dst_single_if.wr_gate = wr_gate;
    assign src_sw_if.wr_val     = wr_val;
    assign dst_sw_if.wr_val     = wr_val;
    assign src_single_if.wr_val = wr_val;
    assign dst_single_if.wr_val = wr_val;

    // Service completion clears pending requests
    assign src_sw_if.done     = SRC_SW_DONE_IN;
    assign dst_sw_if.done     = DST_SW_DONE_IN;
    assign src_single_if.done = SRC_SINGLE_DONE_IN;
    assign dst_single_if.done = DST_SINGLE_DONE_IN;

    req_bank #(.N(N)) u_src_sw     (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .port(src_sw_if));
    req_bank #(.N(N)) u_dst_sw     (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .port(dst_sw_if));
    req_bank #(.N(N)) u_src_single (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .port(src_single_if));
    req_bank #(.N(N)) u_dst_single (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .port(dst_single_if));

    // Request outputs come straight from the bank flip-flops
    assign SRC_SW_REQ_OUT     = src_sw_if.pending;
    assign DST_SW_REQ_OUT     = dst_sw_if.pending;
    assign SRC_SINGLE_REQ_OUT = src_single_if.pending;
    assign DST_SINGLE_REQ_OUT = dst_single_if.pending;

    // Read address decode and data selection
    assign rsel_src_sw     = (ARADDR_IN == SRC_SW_OFFSET);
    assign rsel_dst_sw     = (ARADDR_IN == DST_SW_OFFSET);
    assign rsel_src_single = (ARADDR_IN == SRC_SINGLE_OFFSET);
    assign rsel_dst_single = (ARADDR_IN == DST_SINGLE_OFFSET);
    assign rd_pend = ({N{rsel_src_sw}}     & src_sw_if.pending)
                   | ({N{rsel_dst_sw}}     & dst_sw_if.pending)
                   | ({N{rsel_src_single}} & src_single_if.pending)
                   | ({N{rsel_dst_single}} & dst_single_if.pending);
    assign next_rdata = {{(32-N){1'b0}}, rd_pend};
    assign next_rresp = (rsel_src_sw | rsel_dst_sw | rsel_src_single | rsel_dst_single)
                        ? RESP_OKAY : RESP_SLVERR;

    // Write address channel
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            AWREADY_OUT <= 1'b0;
            aw_full     <= 1'b0;
            aw_addr     <= '0;
        end else if (aw_hs) begin
            AWREADY_OUT <= 1'b0;
            aw_full     <= 1'b1;
            aw_addr     <= AWADDR_IN;
        end else if (do_write) begin
            aw_full <= 1'b0;
        end else if (!aw_full && !BVALID_OUT) begin
            AWREADY_OUT <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            WREADY_OUT <= 1'b0;
            w_full     <= 1'b0;
            w_data     <= '0;
            w_strb     <= '0;
        end else if (w_hs) begin
            WREADY_OUT <= 1'b0;
            w_full     <= 1'b1;
            w_data     <= WDATA_IN;
            w_strb     <= WSTRB_IN;
        end else if (do_write) begin
            w_full <= 1'b0;
        end else if (!w_full && !BVALID_OUT) begin
            WREADY_OUT <= 1'b1;
        end
    end

    // Write response channel
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            BVALID_OUT <= 1'b0;
            BRESP_OUT  <= RESP_OKAY;
        end else if (do_write) begin
            BVALID_OUT <= 1'b1;
            BRESP_OUT  <= wsel_any ? RESP_OKAY : RESP_SLVERR;
        end else if (BREADY_IN) begin
            BVALID_OUT <= 1'b0;
        end
    end

    // Read channel state machine
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            rd_state    <= RD_IDLE;
            ARREADY_OUT <= 1'b0;
            RVALID_OUT  <= 1'b0;
            RDATA_OUT   <= '0;
            RRESP_OUT   <= RESP_OKAY;
        end else begin
            case (rd_state)
                RD_IDLE: begin
                    ARREADY_OUT <= 1'b1;
                    if (ar_hs) begin
                        ARREADY_OUT <= 1'b0;
                        RVALID_OUT  <= 1'b1;
                        RDATA_OUT   <= next_rdata;
                        RRESP_OUT   <= next_rresp;
                        rd_state    <= RD_RESP;
                    end
                end
                RD_RESP: begin
                    if (RREADY_IN) begin
                        RVALID_OUT <= 1'b0;
                        rd_state   <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state    <= RD_IDLE;
                    ARREADY_OUT <= 1'b0;
                    RVALID_OUT  <= 1'b0;
                end
            endcase
        end
    end

    // Gated write lands the written value in the selected register
    property p_src_sw_set;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (do_write && wsel_src_sw) |=>
            ((SRC_SW_REQ_OUT & $past(wr_gate)) == ($past(wr_val) & $past(wr_gate)));
    endproperty
    a_src_sw_set: assert property (p_src_sw_set) else $error("src sw write lost");

    property p_dst_sw_set;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (do_write && wsel_dst_sw) |=>
            ((DST_SW_REQ_OUT & $past(wr_gate)) == ($past(wr_val) & $past(wr_gate)));
    endproperty
    a_dst_sw_set: assert property (p_dst_sw_set) else $error("dst sw write lost");

    property p_src_single_set;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (do_write && wsel_src_single) |=>
            ((SRC_SINGLE_REQ_OUT & $past(wr_gate)) == ($past(wr_val) & $past(wr_gate)));
    endproperty
    a_src_single_set: assert property (p_src_single_set) else $error("src single lost");

    property p_dst_single_set;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (do_write && wsel_dst_single) |=>
            ((DST_SINGLE_REQ_OUT & $past(wr_gate)) == ($past(wr_val) & $past(wr_gate)));
    endproperty
    a_dst_single_set: assert property (p_dst_single_set) else $error("dst single lost");

    // Ungated bits with no service keep their value across a write
    property p_src_sw_hold;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (do_write && wsel_src_sw && SRC_SW_DONE_IN == '0) |=>
            ((SRC_SW_REQ_OUT & ~$past(wr_gate)) == ($past(SRC_SW_REQ_OUT) & ~$past(wr_gate)));
    endproperty
    a_src_sw_hold: assert property (p_src_sw_hold) else $error("src sw gate ignored");

    property p_dst_sw_hold;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (do_write && wsel_dst_sw && DST_SW_DONE_IN == '0) |=>
            ((DST_SW_REQ_OUT & ~$past(wr_gate)) == ($past(DST_SW_REQ_OUT) & ~$past(wr_gate)));
    endproperty
    a_dst_sw_hold: assert property (p_dst_sw_hold) else $error("dst sw gate ignored");

    property p_src_single_hold;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (do_write && wsel_src_single && SRC_SINGLE_DONE_IN == '0) |=>
            ((SRC_SINGLE_REQ_OUT & ~$past(wr_gate))
             == ($past(SRC_SINGLE_REQ_OUT) & ~$past(wr_gate)));
    endproperty
    a_src_single_hold: assert property (p_src_single_hold) else $error("src sgl gate");

    property p_dst_single_hold;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (do_write && wsel_dst_single && DST_SINGLE_DONE_IN == '0) |=>
            ((DST_SINGLE_REQ_OUT & ~$past(wr_gate))
             == ($past(DST_SINGLE_REQ_OUT) & ~$past(wr_gate)));
    endproperty
    a_dst_single_hold: assert property (p_dst_single_hold) else $error("dst sgl gate");

    // Reserved bits of every read answer are zero
    property p_reserved_zero;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        RVALID_OUT |-> (RDATA_OUT[31:3] == 29'h0000000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    // Service pulse without a write clears the source software pending bits
    property p_service_clear;
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (!src_sw_if.wr_stb && SRC_SW_DONE_IN != '0) |=>
            ((SRC_SW_REQ_OUT & $past(SRC_SW_DONE_IN)) == '0);
    endproperty
    a_service_clear: assert property (p_service_clear) else $error("service not cleared");

endmodule // dma_sw_handshake_requests

// ==== dv/dma_sw_handshake_requests_bench.sv ====
// Purpose: Self-checking bench for the software handshake request registers
// Assumes: AXI4-Lite master driven here, done pulses driven here, one clock
// Notes:   Handshakes are judged at the falling edge, so they never race the DUT flops
module dma_sw_handshake_requests_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import swreq_pkg::*;

    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [11:0] awaddr  = 12'h0;
    logic        awvalid = 1'b0;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'h0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic [11:0] araddr  = 12'h0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [2:0]  done_bus [4] = '{3'h0, 3'h0, 3'h0, 3'h0};
    wire logic [2:0] req_bus [4];
    logic [11:0] offs     [4] = '{SRC_SW_OFFSET, DST_SW_OFFSET, SRC_SINGLE_OFFSET,
                                  DST_SINGLE_OFFSET};
    int          failures    = 0;
    int          check_count = 0;

    // Free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    dma_sw_handshake_requests i_dut (
        .SYS_CLK_IN (sys_clk), .RST_IN (rst),
        .AWADDR_IN (awaddr), .AWVALID_IN (awvalid), .AWREADY_OUT (awready),
        .WDATA_IN (wdata), .WSTRB_IN (wstrb), .WVALID_IN (wvalid), .WREADY_OUT (wready),
        .BRESP_OUT (bresp), .BVALID_OUT (bvalid), .BREADY_IN (bready),
        .ARADDR_IN (araddr), .ARVALID_IN (arvalid), .ARREADY_OUT (arready),
        .RDATA_OUT (rdata), .RRESP_OUT (rresp), .RVALID_OUT (rvalid), .RREADY_IN (rready),
        .SRC_SW_DONE_IN (done_bus[0]), .DST_SW_DONE_IN (done_bus[1]),
        .SRC_SINGLE_DONE_IN (done_bus[2]), .DST_SINGLE_DONE_IN (done_bus[3]),
        .SRC_SW_REQ_OUT (req_bus[0]), .DST_SW_REQ_OUT (req_bus[1]),
        .SRC_SINGLE_REQ_OUT (req_bus[2]), .DST_SINGLE_REQ_OUT (req_bus[3])
    );

    // Compare one value and count it
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One AXI4-Lite write; address and data offered together, each released when taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic ah, wh, bh, fin;
        fin = 1'b0;
        r   = 2'h3;
        @(posedge sys_clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!fin) begin
            @(negedge sys_clk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bready & bvalid;
            if (bh) r = bresp;
            @(posedge sys_clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) begin
                bready <= 1'b0;
                fin = 1'b1;
            end
        end
    endtask

    // One AXI4-Lite read; rready held until the data is sampled
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, rh, fin;
        fin = 1'b0;
        d   = 32'hdead_beef;
        r   = 2'h3;
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!fin) begin
            @(negedge sys_clk);
            ah = arvalid & arready;
            rh = rready & rvalid;
            if (rh) begin
                d = rdata;
                r = rresp;
            end
            @(posedge sys_clk);
            if (ah) arvalid <= 1'b0;
            if (rh) begin
                rready <= 1'b0;
                fin = 1'b1;
            end
        end
    endtask

    // Every register and every request output is zero out of reset
    task automatic test_reset();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++) begin
            check({29'h0, req_bus[i]}, 32'h0, "request output after reset");
            axi_read(offs[i], d, r);
            check(d, REQ_RESET, "register reset value");
            check({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
        end
        $display("test reset done");
    endtask

    // Gated writes touch only the enabled channels; gates and reserved bits read zero
    task automatic test_gates(input int i);
        logic [31:0] wr  [7] = '{32'h0000_0107, 32'h0000_0607, 32'h0000_0200, 32'h0000_0007,
                                 32'hffff_f8fa, 32'h0000_0500, 32'hffff_ffff};
        logic [2:0]  exp [7] = '{3'h1, 3'h7, 3'h5, 3'h5, 3'h5, 3'h0, 3'h7};
        logic [31:0] d;
        logic [1:0]  r;
        for (int k = 0; k < 7; k++) begin
            axi_write(offs[i], wr[k], 4'hf, r);
            check({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
            axi_read(offs[i], d, r);
            check(d, {29'h0, exp[k]}, "register readback");
            @(negedge sys_clk);
            check({29'h0, req_bus[i]}, {29'h0, exp[k]}, "request output");
        end
        // Neighbouring registers stay untouched
        for (int j = 0; j < 4; j++) begin
            if (j != i) check({29'h0, req_bus[j]}, 32'h0, "neighbour disturbed");
        end
        axi_write(offs[i], 32'h0000_0700, 4'hf, r);
        $display("test gates on register %0d done", i);
    endtask

    // A service pulse clears only its own channel; a half-strobe write does nothing
    task automatic test_done();
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            axi_write(offs[i], 32'h0000_0707, 4'hf, r);
            axi_write(offs[i], 32'h0000_0700, 4'h1, r);
            check({30'h0, r}, {30'h0, RESP_OKAY}, "half-strobe response");
            @(negedge sys_clk);
            check({29'h0, req_bus[i]}, 32'h7, "half-strobe write");
            @(posedge sys_clk);
            done_bus[i] <= 3'h2;
            @(posedge sys_clk);
            done_bus[i] <= 3'h0;
            @(negedge sys_clk);
            check({29'h0, req_bus[i]}, 32'h5, "service clear");
        end
        $display("test done pulses done");
    endtask

    // Addresses outside the four registers answer with an error and change nothing
    task automatic test_unmapped();
        logic [11:0] bad [3] = '{12'h36c, 12'h388, 12'h000};
        logic [31:0] d;
        logic [1:0]  r;
        for (int k = 0; k < 3; k++) begin
            axi_write(bad[k], 32'hffff_ffff, 4'hf, r);
            check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write response");
            axi_read(bad[k], d, r);
            check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read response");
            check(d, 32'h0, "unmapped read data");
        end
        @(negedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            check({29'h0, req_bus[i]}, 32'h5, "unmapped write leaked");
        end
        $display("test unmapped done");
    endtask

    // Print the counts and the verdict, then stop
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset();
        for (int i = 0; i < 4; i++) test_gates(i);
        test_done();
        test_unmapped();
        print_verdict();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule // dma_sw_handshake_requests_bench
